/* shared/clock_ctl_pkg.sv */
package clock_ctl_pkg;
  localparam logic [1:0] sel_dco = 2'h0;
  localparam logic [1:0] sel_xt2 = 2'h2;
  localparam logic [1:0] sel_lfxt = 2'h3;
  localparam logic [1:0] sel_vlo = 2'h1;
  localparam logic [1:0] range_vlo = 2'h2;
  localparam logic [1:0] range_ext = 2'h3;
  localparam logic [1:0] cap_none = 2'h0;
  localparam logic [1:0] cap_6pf = 2'h1;
  localparam logic [1:0] div_reset = 2'h0;
  localparam logic [1:0] main_sel_reset = 2'h0;
  localparam logic [2:0] div_count_zero = 3'h0;
  typedef enum logic [1:0] {
    sw_run = 2'b00,
    sw_wait_old = 2'b01,
    sw_wait_new = 2'b10
  } switch_state_t;
  typedef struct packed {
    logic [1:0] main_sel;
    logic [1:0] main_div;
    logic [1:0] sub_sel;
    logic [1:0] sub_div;
    logic aux_sel_vlo;
    logic [1:0] aux_div;
    logic [1:0] range_select;
    logic hf_mode;
    logic [1:0] load_cap;
  } clock_cfg_t;
  typedef struct packed {
    logic digital_osc_gate;
    logic sub_main_clock_gate;
    logic oscillator_disable;
    logic cpu_halt;
  } sr_bits_t;
  typedef struct packed {
    logic low_freq_crystal_clock;
    logic very_low_power_osc_clock;
    logic second_crystal_clock;
    logic digital_osc_clock;
  } osc_in_t;
endpackage

/* core/clock_source_select_divide.sv */
`timescale 1ns/10ps
`default_nettype none
module clock_source_select_divide
  import clock_ctl_pkg::*;
#(
  parameter int div_width = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire clock_cfg_t cfg,
  input wire sr_bits_t sr_bits,
  input wire osc_in_t osc_in,
  input wire logic crystal1_fault,
  input wire logic crystal2_fault,
  input wire logic osc_fault_flag_clear,
  input wire logic osc_fault_irq_enable_set,
  input wire logic nmi_grant,
  output logic aux_clock,
  output logic main_clock,
  output logic sub_main_clock,
  output logic cpu_clock,
  output logic crystal1_enable,
  output logic crystal1_hf_active,
  output logic crystal1_external_in,
  output logic [1:0] crystal1_cap_trim,
  output logic [1:0] crystal1_hf_range,
  output logic very_low_power_osc_enable,
  output logic digital_osc_enable,
  output logic crystal2_enable,
  output logic osc_fault_flag,
  output logic osc_fault_irq_enable,
  output logic nmi_request
);
  if (div_width != 3) begin : g_width_check
    $error("div_width must be 3 for dividers of 1 to 8");
  end
  logic rst_sync1;
  logic rst_sync;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1 <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_sync <= rst_sync1;
    end
  end
  function automatic logic pick(input osc_in_t o, input logic [1:0] s);
    case (s)
      sel_dco: pick = o.digital_osc_clock;
      sel_vlo: pick = o.very_low_power_osc_clock;
      sel_xt2: pick = o.second_crystal_clock;
      sel_lfxt: pick = o.low_freq_crystal_clock;
      default: pick = o.digital_osc_clock;
    endcase
  endfunction
  // Sources are sampled at the system clock; the 50 MHz reference must outrun every oscillator.
  logic vlo_chosen;
  logic main_eff_sel_is_x1;
  logic [1:0] main_eff_sel;
  assign vlo_chosen = (cfg.range_select == range_vlo) && !cfg.hf_mode;
  // Fault on the selected crystal overrides the route only, never cfg.main_sel.
  assign main_eff_sel_is_x1 = (cfg.main_sel == sel_lfxt) && crystal1_fault;
  assign main_eff_sel = (main_eff_sel_is_x1 || (cfg.main_sel == sel_xt2 && crystal2_fault))
                        ? sel_dco : cfg.main_sel;
  logic x1_used;
  logic dco_used;
  logic x2_used;
  assign x1_used = (main_eff_sel == sel_lfxt) ||
                   (!sr_bits.sub_main_clock_gate && cfg.sub_sel == sel_lfxt) || !cfg.aux_sel_vlo;
  assign dco_used = (main_eff_sel == sel_dco && !sr_bits.cpu_halt) ||
                    (!sr_bits.sub_main_clock_gate && cfg.sub_sel == sel_dco);
  assign x2_used = (main_eff_sel == sel_xt2) ||
                   (!sr_bits.sub_main_clock_gate && cfg.sub_sel == sel_xt2);
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      crystal1_enable <= 1'b1;
      crystal1_hf_active <= 1'b0;
      crystal1_external_in <= 1'b0;
      crystal1_cap_trim <= cap_6pf;
      crystal1_hf_range <= cap_none;
      very_low_power_osc_enable <= 1'b0;
      digital_osc_enable <= 1'b1;
      crystal2_enable <= 1'b0;
    end else begin
      // Oscillator disable wins unless main or sub-main still needs crystal1.
      crystal1_enable <= !vlo_chosen &&
                         (!sr_bits.oscillator_disable || (main_eff_sel == sel_lfxt) ||
                          (!sr_bits.sub_main_clock_gate && cfg.sub_sel == sel_lfxt)) &&
                         x1_used;
      crystal1_hf_active <= cfg.hf_mode && (cfg.load_cap == cap_none);
      crystal1_external_in <= (cfg.range_select == range_ext) && !sr_bits.oscillator_disable &&
                              (cfg.load_cap == cap_none);
      crystal1_cap_trim <= cfg.hf_mode ? cap_none : cfg.load_cap;
      crystal1_hf_range <= cfg.hf_mode ? cfg.range_select : cap_none;
      very_low_power_osc_enable <= vlo_chosen && !sr_bits.oscillator_disable;
      digital_osc_enable <= !sr_bits.digital_osc_gate || dco_used;
      crystal2_enable <= x2_used;
    end
  end
  // Enables of the four sources in the same order as the oscillator inputs.
  osc_in_t osc_on;
  assign osc_on = {crystal1_enable, very_low_power_osc_enable, crystal2_enable,
                   digital_osc_enable};
  // Glitch-free switch: each lane holds its divided output high across a change.
  logic [1:0] src_sel [3];
  logic [1:0] src_div [3];
  logic src_gate [3];
  logic lane_out [3];
  assign src_sel[0] = cfg.aux_sel_vlo ? sel_vlo : sel_lfxt;
  assign src_sel[1] = main_eff_sel;
  assign src_sel[2] = cfg.sub_sel;
  assign src_div[0] = cfg.aux_div;
  assign src_div[1] = cfg.main_div;
  assign src_div[2] = cfg.sub_div;
  assign src_gate[0] = 1'b1;
  assign src_gate[1] = 1'b1;
  assign src_gate[2] = !sr_bits.sub_main_clock_gate;
  for (genvar i = 0; i < 3; i++) begin : g_lane
    switch_state_t state;
    logic [1:0] cur_sel;
    logic [1:0] cur_div;
    logic src_prev;
    logic src_now;
    logic new_now;
    logic out;
    logic [div_width-1:0] count;
    logic rise_cur;
    logic rise_new;
    logic edge_cur;
    logic [1:0] next_div;
    assign src_now = pick(osc_in, cur_sel);
    assign new_now = pick(osc_in, src_sel[i]);
    assign rise_cur = src_now && !src_prev;
    assign edge_cur = src_now != src_prev;
    assign next_div = (!out || cur_div == div_reset) ? src_div[i] : cur_div;
    always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
        src_prev <= 1'b0;
      end else begin
        // Take the new source's level on the switch so that it shows no false edge.
        src_prev <= (state == sw_wait_new && rise_new) ? new_now : src_now;
      end
    end
    logic new_prev;
    always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
        new_prev <= 1'b0;
      end else begin
        new_prev <= new_now;
      end
    end
    assign rise_new = new_now && !new_prev;
    always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
        state <= sw_run;
        cur_sel <= (i == 0) ? sel_lfxt : main_sel_reset;
        cur_div <= div_reset;
        count <= div_count_zero;
        out <= 1'b1;
      end else begin
        case (state)
          sw_run: begin
            if (src_sel[i] != cur_sel) begin
              state <= sw_wait_old;
            end else if (edge_cur) begin
              // Half period is 2^div source edges, so a ratio of 1 passes the source through.
              if (count == div_count_zero) begin
                out <= !out;
                cur_div <= next_div;
                count <= div_width'((1 << next_div) - 1);
              end else begin
                count <= count - 1'b1;
              end
            end
          end
          sw_wait_old: begin
            // A source that was switched off never rises again; waiting for it would hang.
            if (rise_cur || !pick(osc_on, cur_sel)) begin
              out <= 1'b1;
              state <= sw_wait_new;
            end
          end
          sw_wait_new: begin
            if (rise_new) begin
              cur_sel <= src_sel[i];
              cur_div <= src_div[i];
              count <= div_width'((1 << src_div[i]) - 1);
              state <= sw_run;
            end
          end
          default: state <= sw_run;
        endcase
      end
    end
    // Gate closes only while the lane is low so no partial pulse leaks out.
    logic gated;
    always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
        gated <= 1'b1;
      end else if (!out) begin
        gated <= src_gate[i];
      end
    end
    always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
        lane_out[i] <= 1'b0;
      end else begin
        lane_out[i] <= out && gated;
      end
    end
  end
  assign aux_clock = lane_out[0];
  assign main_clock = lane_out[1];
  assign sub_main_clock = lane_out[2];
  logic cpu_run;
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      cpu_run <= 1'b1;
    end else if (!g_lane[1].out) begin
      cpu_run <= !sr_bits.cpu_halt;
    end
  end
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      cpu_clock <= 1'b0;
    end else begin
      cpu_clock <= g_lane[1].out && cpu_run;
    end
  end
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      osc_fault_flag <= 1'b1;
    end else if (crystal1_fault || crystal2_fault) begin
      osc_fault_flag <= 1'b1;
    end else if (osc_fault_flag_clear) begin
      osc_fault_flag <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      osc_fault_irq_enable <= 1'b0;
    end else if (nmi_grant && nmi_request) begin
      osc_fault_irq_enable <= 1'b0;
    end else if (osc_fault_irq_enable_set) begin
      osc_fault_irq_enable <= 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      nmi_request <= 1'b0;
    end else begin
      nmi_request <= osc_fault_flag && osc_fault_irq_enable && !nmi_grant;
    end
  end
endmodule // clock_source_select_divide
`default_nettype wire

/* verif/clock_ctl_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module clock_ctl_sva
  import clock_ctl_pkg::*;
#(
  parameter int div_width = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire clock_cfg_t cfg,
  input wire sr_bits_t sr_bits,
  input wire logic crystal1_fault,
  input wire logic crystal2_fault,
  input wire logic nmi_grant,
  input wire logic osc_fault_irq_enable_set,
  input wire logic crystal1_enable,
  input wire logic crystal1_hf_active,
  input wire logic crystal1_external_in,
  input wire logic [1:0] crystal1_cap_trim,
  input wire logic very_low_power_osc_enable,
  input wire logic digital_osc_enable,
  input wire logic osc_fault_flag,
  input wire logic osc_fault_irq_enable,
  input wire logic nmi_request
);
  // Inputs only count once the two-flop reset copy inside is surely out.
  logic [2:0] age;
  logic live;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      age <= 3'h0;
    end else if (!live) begin
      age <= age + 3'h1;
    end
  end
  assign live = age == 3'h7;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_VLO_OFF: assert property (
    live && sr_bits.oscillator_disable |=> !very_low_power_osc_enable)
    else $error("very low power osc left on");
  AST_HF_MODE: assert property (
    live && cfg.hf_mode && cfg.load_cap == cap_none |=> crystal1_hf_active)
    else $error("crystal1 not in hf mode");
  AST_EXT_IN: assert property (
    live && cfg.range_select == range_ext && !sr_bits.oscillator_disable
    && cfg.load_cap == cap_none |=> crystal1_external_in)
    else $error("external input not accepted");
  AST_CAP: assert property (
    live && !cfg.hf_mode |=> crystal1_cap_trim == $past(cfg.load_cap))
    else $error("load cap trim wrong");
  AST_XT1_OFF: assert property (
    (live && sr_bits.oscillator_disable && cfg.main_sel != sel_lfxt
    && cfg.sub_sel != sel_lfxt) [*4] |=> !crystal1_enable)
    else $error("crystal1 left on");
  AST_DCO_OFF: assert property (
    (live && sr_bits.digital_osc_gate && cfg.main_sel != sel_dco && cfg.sub_sel != sel_dco
    && !crystal1_fault && !crystal2_fault && !osc_fault_flag) [*4] |=> !digital_osc_enable)
    else $error("digital osc left on");
  AST_NMI: assert property (
    live && osc_fault_flag && osc_fault_irq_enable && !nmi_grant |=> nmi_request)
    else $error("nmi not requested");
  AST_GRANT: assert property (
    live && nmi_grant && nmi_request |=> !osc_fault_irq_enable)
    else $error("irq enable not cleared");
  cover property (live && nmi_request && nmi_grant);
  cover property (live && crystal1_external_in);
  cover property (live && !digital_osc_enable);
endmodule // clock_ctl_sva
bind clock_source_select_divide clock_ctl_sva #(.div_width(div_width)) i_sva (
  .clock, .rst_n, .cfg, .sr_bits, .crystal1_fault, .crystal2_fault, .nmi_grant,
  .osc_fault_irq_enable_set, .crystal1_enable, .crystal1_hf_active, .crystal1_external_in,
  .crystal1_cap_trim, .very_low_power_osc_enable, .digital_osc_enable, .osc_fault_flag,
  .osc_fault_irq_enable, .nmi_request
);
`default_nettype wire

/* verif/osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module osc_model
  import clock_ctl_pkg::*;
(
  input wire logic clock,
  input wire logic [3:0] run,
  output var osc_in_t osc
);
  // Half periods in clock cycles: crystal1 4, vlo 5, crystal2 3, digital 2.
  localparam logic [15:0] half = 16'h4532;
  logic [3:0] cnt [4] = '{default: 4'h0};
  logic [3:0] lvl = 4'h0;
  // A stopped oscillator stands low, like a real one that is switched off.
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (!run[i]) begin
        lvl[i] <= 1'b0;
        cnt[i] <= 4'h0;
      end else if (cnt[i] == half[i*4 +: 4] - 4'h1) begin
        lvl[i] <= !lvl[i];
        cnt[i] <= 4'h0;
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
  assign osc = lvl;
endmodule // osc_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module testbench;
  import clock_ctl_pkg::*;
  localparam clock_cfg_t base = '{load_cap: cap_6pf, default: '0};
  logic clock, rst_n, f1, f2, clr, ien, grant;
  logic aux_clock, main_clock, sub_main_clock, cpu_clock, c1_en, vlo_en, dco_en, c2_en;
  logic hf_act, ext_in, flag, irq_en, nmi;
  logic [1:0] trim, hf_range;
  logic [3:0] clks;
  clock_cfg_t cfg, c;
  sr_bits_t sr;
  osc_in_t osc;
  int n_fail = 0, total_checks = 0, p;
  int per [4] = '{4, 10, 6, 8};
  initial begin
    clock = 1'b0;
    forever #10 clock = !clock;
  end
  assign clks = {cpu_clock, sub_main_clock, main_clock, aux_clock};
  osc_model i_osc (.clock(clock), .run({c1_en, vlo_en, c2_en, dco_en}), .osc(osc));
  clock_source_select_divide i_dut (.clock(clock), .rst_n(rst_n), .cfg(cfg), .sr_bits(sr),
    .osc_in(osc), .crystal1_fault(f1), .crystal2_fault(f2), .osc_fault_flag_clear(clr),
    .osc_fault_irq_enable_set(ien), .nmi_grant(grant), .aux_clock(aux_clock),
    .main_clock(main_clock), .sub_main_clock(sub_main_clock), .cpu_clock(cpu_clock),
    .crystal1_enable(c1_en), .crystal1_hf_active(hf_act), .crystal1_external_in(ext_in),
    .crystal1_cap_trim(trim), .crystal1_hf_range(hf_range), .very_low_power_osc_enable(vlo_en),
    .digital_osc_enable(dco_en), .crystal2_enable(c2_en), .osc_fault_flag(flag),
    .osc_fault_irq_enable(irq_en), .nmi_request(nmi));
  task setc(input clock_cfg_t v, input logic [3:0] s);
    @(posedge clock);
    cfg <= v;
    sr <= sr_bits_t'(s);
    repeat (3) @(posedge clock);
    #1;
  endtask
  // Cycles between the 3rd and 4th rise; 900 means the clock stood still.
  task meas(input int w, output int q);
    int r;
    logic o;
    r = 0;
    q = 0;
    o = clks[w];
    while (r < 4 && q < 900) begin
      @(posedge clock);
      #1;
      q++;
      if (clks[w] && !o) begin
        r++;
        if (r < 4) q = 0;
      end
      o = clks[w];
    end
  endtask
  task results;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    results();
  end
  initial begin
    {rst_n, f1, f2, clr, ien, grant} = '0;
    cfg = base;
    sr = '0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(trim, cap_6pf)
    `CHK(dco_en, 1'b1)
    `CHK(flag, 1'b1)
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    setc(base, 4'h0);
    `CHK(flag, 1'b0)
    meas(0, p);
    `CHK(p, 8)
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        c = base;
        {c.main_sel, c.main_div, c.aux_div} = {s[1:0], d[1:0], d[1:0]};
        {c.sub_sel, c.sub_div, c.aux_sel_vlo} = {2'(3 - s), 2'(3 - d), s[0] ^ s[1]};
        c.range_select = (s[0] ^ s[1]) ? range_vlo : 2'h0;
        setc(c, 4'h0);
        meas(1, p);
        `CHK(p, per[s] << d)
        meas(2, p);
        `CHK(p, per[3 - s] << (3 - d))
        meas(0, p);
        `CHK(p, ((s[0] ^ s[1]) ? 10 : 8) << d)
      end
    end
    c = base;
    c.main_sel = sel_lfxt;
    setc(c, 4'h0);
    @(posedge clock);
    f1 <= 1'b1;
    meas(1, p);
    `CHK(p, 4)
    `CHK(flag, 1'b1)
    @(posedge clock);
    {f1, ien} <= 2'h1;
    @(posedge clock);
    ien <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(nmi, 1'b1)
    @(posedge clock);
    grant <= 1'b1;
    @(posedge clock);
    {grant, clr} <= 2'h1;
    @(posedge clock);
    clr <= 1'b0;
    setc(base, 4'h0);
    `CHK(irq_en, 1'b0)
    meas(3, p);
    `CHK(p, 4)
    setc(base, 4'h5);
    meas(3, p);
    `CHK(p, 900)
    meas(2, p);
    `CHK(p, 900)
    for (int i = 0; i < 4; i++) begin
      c = base;
      c.load_cap = i[1:0];
      setc(c, 4'h0);
      `CHK(trim, i[1:0])
      {c.hf_mode, c.load_cap, c.range_select} = {1'b1, cap_none, i[1:0]};
      setc(c, 4'h0);
      `CHK(hf_range, i[1:0])
      `CHK(ext_in, i == 3)
      `CHK(hf_act, 1'b1)
    end
    c = base;
    c.range_select = range_vlo;
    setc(c, 4'h0);
    `CHK(c1_en, 1'b0)
    `CHK(vlo_en, 1'b1)
    setc(c, 4'h2);
    `CHK(vlo_en, 1'b0)
    setc(base, 4'h2);
    repeat (3) @(posedge clock);
    #1;
    `CHK(c1_en, 1'b0)
    c.range_select = 2'h0;
    c.main_sel = sel_lfxt;
    setc(c, 4'h2);
    `CHK(c1_en, 1'b1)
    {c.main_sel, c.sub_sel} = {sel_xt2, sel_xt2};
    setc(c, 4'h8);
    repeat (3) @(posedge clock);
    #1;
    `CHK(dco_en, 1'b0)
    `CHK(c2_en, 1'b1)
    results();
  end
endmodule // testbench
`default_nettype wire
